// ==== design/cocr_regs.svh ====
// Purpose: Offsets, field positions, reset values and output indices of the clock output control bank
// Assumes: Six 8-bit control bytes reached over the two-wire serial target port
// Notes:   One line per rule follows
// Operation
// - Byte 0 bit 7 drives selectable pair
// - Byte 0 bits 4..1 drive serial pairs 3..0
// - Byte 1 bit 7 picks down spread
// - Byte 1 bit 0 turns spread on
// - Byte 1 bits 6,2,1 drive video, processor pairs
// - Byte 1 bits 5,4,3 enable usb, crystal outputs
// - Byte 2 bits 7,6,3,2 enable bus clocks
// - Byte 2 bits 1,0 enable free-run clocks
// - Byte 3 marks serial pairs stoppable
// - Byte 4 bits 5,4 mark free-run stoppable
// - Byte 4 bit 6 floats video in power-down
// - Byte 5 bit 7 floats stopped serial pairs
// - Byte 5 bit 3 floats serial pairs powered-down
// - Byte 5 bits 1,0 float processor pairs powered-down, bit 2 the selectable pair
// - Command bit 7 picks byte or block
// - Only target address 1101001x (bytes 11010010, 11010011) is answered
// - All bytes load defaults at reset
// - Stop and resume cleanly, no short pulses
`ifndef COCR_REGS_SVH
`define COCR_REGS_SVH
// ==========================================================
// Bank layout
`define COCR_NUM_REGS      6
`define COCR_PTR_LIMIT     7'h06
`define COCR_BLOCK_COUNT   8'h06
`define COCR_TARGET_ADDR   7'h69
`define COCR_CMD_BYTE_MODE 7
// ==========================================================
// Reset values
`define COCR_RST_B0        8'hff
`define COCR_RST_B1        8'hfe
`define COCR_RST_B2        8'hff
`define COCR_RST_B3        8'h00
`define COCR_RST_B4        8'h07
`define COCR_RST_B5        8'h00
// ==========================================================
// Field positions
`define COCR_SPREAD_DOWN   7
`define COCR_SPREAD_ON     0
`define COCR_VIDEO_PD_HIZ  6
`define COCR_FR0_STOP      4
`define COCR_FR1_STOP      5
`define COCR_SRC_STOP_HIZ  7
`define COCR_SRC_PD_HIZ    3
// ==========================================================
// Output indices: 0 selectable, 1..4 serial 0..3, 5 video, 6..7 processor 0..1,
// 8 usb, 9..10 crystal 0..1, 11..14 bus 0..3, 15..16 free-run 0..1
`define COCR_NUM_OUTS      17
`define COCR_NUM_DIFF      8
`endif

// ==== design/cocr_pkg.sv ====
// Purpose: Types shared by the clock output control bank
// Assumes: Constants come from cocr_regs.svh
// Notes:   State of each module is one packed struct
`include "cocr_regs.svh"
package cocr_pkg;
    // ==========================================================
    // Serial target sequencer
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_CMD, S_COUNT, S_WDATA, S_ACK, S_TX, S_RACK
    } cocr_state_t;

    typedef struct packed {
        cocr_state_t                           st;
        cocr_state_t                           after;
        logic [3:0]                            bit_cnt;
        logic [7:0]                            shreg;
        logic [6:0]                            ptr;
        logic                                  cnt_pend;
        logic                                  mack;
        logic                                  scl_q;
        logic                                  sda_q;
        logic                                  sda_oe_n;
        logic                                  ss_on;
        logic                                  ss_down;
        logic [`COCR_NUM_REGS-1:0][7:0]        regs;
    } cocr_slv_t;

    // ==========================================================
    // One clean output gate
    typedef struct packed {
        logic run_q;
        logic out;
        logic oe_n;
    } cocr_gate_t;
endpackage : cocr_pkg

// ==== design/cocr_out_gate.sv ====
// Purpose: Gates one clock output so it starts and stops only on a low phase
// Assumes: src_level sampled synchronous to ref_clk
// Notes:   Drive mode is latched with the run state, so the pin floats only at a boundary
`timescale 1ns/1ps
module cocr_out_gate (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic src_level,
    input  wire logic run,
    input  wire logic hiz,
    output logic      out,
    output logic      oe_n
);
    import cocr_pkg::*;

    cocr_gate_t s_r;
    cocr_gate_t s_nxt;
    logic       run_eff;

    // ==========================================================
    // Run state only follows the request while the source is low,
    // so a high phase is never cut short
    always_comb begin
        s_nxt   = s_r;
        run_eff = src_level ? s_r.run_q : run;
        s_nxt.run_q = run_eff;
        s_nxt.out   = src_level & run_eff;          // Parked low when stopped
        if (!src_level) begin
            s_nxt.oe_n = run ? 1'b0 : hiz;
        end
    end

    // Outputs enabled and driven after reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '{run_q: 1'b1, out: 1'b0, oe_n: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign out  = s_r.out;
    assign oe_n = s_r.oe_n;
endmodule : cocr_out_gate

// ==== design/cocr_ctrl.sv ====
// Purpose: Clock output control bank with its two-wire serial target port
// Assumes: scl and sda_in synchronous to ref_clk and slow against it
// Notes:   Unmapped offsets read zero and ignore writes; byte count of a block write is ignored
`timescale 1ns/1ps
`include "cocr_regs.svh"
module cocr_ctrl (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic                       scl,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe_n,
    input  wire logic                       sw_bus_clock_stop,
    input  wire logic                       power_down,
    input  wire logic [`COCR_NUM_OUTS-1:0]  src_clk,
    output logic      [`COCR_NUM_OUTS-1:0]  clk_out,
    output logic      [`COCR_NUM_OUTS-1:0]  clk_oe_n,
    output logic                            spread_on,
    output logic                            spread_down
);
    import cocr_pkg::*;

    cocr_slv_t                  s_r;
    cocr_slv_t                  s_nxt;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       start_cond;
    logic                       stop_cond;
    logic [`COCR_NUM_OUTS-1:0]  en_vec;
    logic [`COCR_NUM_OUTS-1:0]  stoppable;
    logic [`COCR_NUM_OUTS-1:0]  stop_hiz;
    logic [`COCR_NUM_OUTS-1:0]  pd_hiz;
    logic [`COCR_NUM_OUTS-1:0]  run_vec;
    logic [`COCR_NUM_OUTS-1:0]  hiz_vec;

    // ==========================================================
    // Register read decode, used by both transmit load points
    function automatic logic [7:0] rd_byte(
        input logic [`COCR_NUM_REGS-1:0][7:0] regs,
        input logic [6:0]                     ptr
    );
        rd_byte = 8'h00;
        if (ptr < `COCR_PTR_LIMIT) begin
            rd_byte = regs[ptr[2:0]];
        end
    endfunction : rd_byte

    // ==========================================================
    // Bus condition detection
    assign scl_rise   = scl & ~s_r.scl_q;
    assign scl_fall   = ~scl & s_r.scl_q;
    assign start_cond = scl & s_r.scl_q & s_r.sda_q & ~sda_in;
    assign stop_cond  = scl & s_r.scl_q & ~s_r.sda_q & sda_in;

    // ==========================================================
    // Serial target sequencer and register bank
    always_comb begin
        s_nxt       = s_r;
        s_nxt.scl_q = scl;
        s_nxt.sda_q = sda_in;
        s_nxt.ss_on   = s_r.regs[1][`COCR_SPREAD_ON];
        s_nxt.ss_down = s_r.regs[1][`COCR_SPREAD_DOWN];
        if (start_cond) begin
            // A repeated start keeps the pointer set by the command byte
            s_nxt.st       = S_ADDR;
            s_nxt.bit_cnt  = 4'h0;
            s_nxt.sda_oe_n = 1'b1;
        end else if (stop_cond) begin
            s_nxt.st       = S_IDLE;
            s_nxt.sda_oe_n = 1'b1;
        end else begin
            unique case (s_r.st)
                S_IDLE: begin
                    s_nxt.sda_oe_n = 1'b1;
                end
                S_ADDR, S_CMD, S_COUNT, S_WDATA: begin
                    if (scl_rise) begin
                        s_nxt.shreg   = {s_r.shreg[6:0], sda_in};
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    end else if (scl_fall && s_r.bit_cnt == 4'h8) begin
                        s_nxt.bit_cnt  = 4'h0;
                        s_nxt.st       = S_ACK;
                        s_nxt.sda_oe_n = 1'b0;              // Acknowledge low
                        unique case (s_r.st)
                            S_ADDR: begin
                                if (s_r.shreg[7:1] != `COCR_TARGET_ADDR) begin
                                    // Foreign address: stay silent until next start
                                    s_nxt.st       = S_IDLE;
                                    s_nxt.sda_oe_n = 1'b1;
                                end else if (s_r.shreg[0]) begin
                                    s_nxt.after = S_TX;
                                end else begin
                                    s_nxt.after = S_CMD;
                                end
                            end
                            S_CMD: begin
                                if (s_r.shreg[`COCR_CMD_BYTE_MODE]) begin
                                    s_nxt.ptr      = s_r.shreg[6:0];
                                    s_nxt.cnt_pend = 1'b0;
                                    s_nxt.after    = S_WDATA;
                                end else begin
                                    s_nxt.ptr      = 7'h00;
                                    s_nxt.cnt_pend = 1'b1;
                                    s_nxt.after    = S_COUNT;
                                end
                            end
                            S_COUNT: begin
                                s_nxt.cnt_pend = 1'b0;
                                s_nxt.after    = S_WDATA;
                            end
                            default: begin
                                // Whole byte stored, reserved bits too
                                if (s_r.ptr < `COCR_PTR_LIMIT) begin
                                    s_nxt.regs[s_r.ptr[2:0]] = s_r.shreg;
                                end
                                s_nxt.ptr   = s_r.ptr + 7'h01;
                                s_nxt.after = S_WDATA;
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        s_nxt.st       = s_r.after;
                        s_nxt.sda_oe_n = 1'b1;
                        if (s_r.after == S_TX) begin
                            // Block read sends the byte count first
                            if (s_r.cnt_pend) begin
                                s_nxt.shreg    = `COCR_BLOCK_COUNT;
                                s_nxt.cnt_pend = 1'b0;
                            end else begin
                                s_nxt.shreg = rd_byte(s_r.regs, s_r.ptr);
                                s_nxt.ptr   = s_r.ptr + 7'h01;
                            end
                            s_nxt.sda_oe_n = s_nxt.shreg[7];
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (s_r.bit_cnt == 4'h7) begin
                            s_nxt.bit_cnt  = 4'h0;
                            s_nxt.st       = S_RACK;
                            s_nxt.sda_oe_n = 1'b1;          // Let controller answer
                        end else begin
                            s_nxt.bit_cnt  = s_r.bit_cnt + 4'h1;
                            s_nxt.shreg    = {s_r.shreg[6:0], 1'b0};
                            s_nxt.sda_oe_n = s_r.shreg[6];
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        s_nxt.mack = ~sda_in;
                    end else if (scl_fall) begin
                        if (s_r.mack) begin
                            s_nxt.st       = S_TX;
                            s_nxt.shreg    = rd_byte(s_r.regs, s_r.ptr);
                            s_nxt.ptr      = s_r.ptr + 7'h01;
                            s_nxt.sda_oe_n = s_nxt.shreg[7];
                        end else begin
                            s_nxt.st = S_IDLE;              // Not acknowledged: done
                        end
                    end
                end
            endcase
        end
    end

    // Defaults load on reset so the outputs run without any host access
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r          <= '0;
            s_r.st       <= S_IDLE;
            s_r.after    <= S_IDLE;
            s_r.scl_q    <= 1'b1;
            s_r.sda_q    <= 1'b1;
            s_r.sda_oe_n <= 1'b1;
            s_r.ss_down  <= 1'b1;
            s_r.regs     <= {`COCR_RST_B5, `COCR_RST_B4, `COCR_RST_B3,
                             `COCR_RST_B2, `COCR_RST_B1, `COCR_RST_B0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_out     = 1'b0;      // Open drain: only ever pulls low
    assign sda_oe_n    = s_r.sda_oe_n;
    assign spread_on   = s_r.ss_on;
    assign spread_down = s_r.ss_down;

    // ==========================================================
    // Per-output enable map
    assign en_vec = {s_r.regs[2][1], s_r.regs[2][0],
                     s_r.regs[2][7], s_r.regs[2][6],
                     s_r.regs[2][3], s_r.regs[2][2],
                     s_r.regs[1][3], s_r.regs[1][4], s_r.regs[1][5],
                     s_r.regs[1][2], s_r.regs[1][1], s_r.regs[1][6],
                     s_r.regs[0][4], s_r.regs[0][3],
                     s_r.regs[0][2], s_r.regs[0][1],
                     s_r.regs[0][7]};

    // Which outputs halt under the software stop; plain bus clocks always do
    assign stoppable = {s_r.regs[4][`COCR_FR1_STOP], s_r.regs[4][`COCR_FR0_STOP],
                        4'hf, 6'h00,
                        s_r.regs[3][4], s_r.regs[3][3], s_r.regs[3][2],
                        s_r.regs[3][1], s_r.regs[3][7]};

    // Float or drive while stopped: only the selectable and serial-reference pairs may float
    assign stop_hiz = {12'h000, {5{s_r.regs[5][`COCR_SRC_STOP_HIZ]}}};

    // Float or drive while powered down
    assign pd_hiz = {9'h000, s_r.regs[5][1], s_r.regs[5][0],
                     s_r.regs[4][`COCR_VIDEO_PD_HIZ],
                     {4{s_r.regs[5][`COCR_SRC_PD_HIZ]}},
                     s_r.regs[5][2]};

    // ==========================================================
    // Output gates; disabled pairs float, disabled single-ended outputs park low
    genvar gi;
    generate
        for (gi = 0; gi < `COCR_NUM_OUTS; gi = gi + 1) begin : g_out
            assign run_vec[gi] = en_vec[gi] & ~(sw_bus_clock_stop & stoppable[gi]) & ~power_down;
            assign hiz_vec[gi] = (~en_vec[gi] & (gi < `COCR_NUM_DIFF))
                               | (sw_bus_clock_stop & stoppable[gi] & stop_hiz[gi])
                               | (power_down & pd_hiz[gi]);
            cocr_out_gate u_gate (
                .ref_clk   (ref_clk),
                .rst       (rst),
                .src_level (src_clk[gi]),
                .run       (run_vec[gi]),
                .hiz       (hiz_vec[gi]),
                .out       (clk_out[gi]),
                .oe_n      (clk_oe_n[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_src_low_1;
        !src_clk[1];
    endsequence

    sequence s_stop_req_1;
        sw_bus_clock_stop && s_r.regs[3][1] && !power_down;
    endsequence

    a_reset_defaults: assert property (disable iff (1'b0) rst |=> (s_r.regs[1] == `COCR_RST_B1 && s_r.regs[4] == `COCR_RST_B4))
        else $error("Control bytes not at defaults after reset");

    a_spread_follows: assert property ($changed(s_r.regs[1][0]) |-> ##1 spread_on == $past(s_r.regs[1][0]))
        else $error("Spread enable output does not follow byte 1 bit 0");

    a_spread_mode: assert property (##1 spread_down == $past(s_r.regs[1][7]))
        else $error("Spread profile output does not follow byte 1 bit 7");

    a_sel_pair_hiz: assert property ((!s_r.regs[0][7] && !src_clk[0]) |=> clk_oe_n[0] && !clk_out[0])
        else $error("Disabled selectable pair not floating");

    a_src_pair_hiz: assert property ((!s_r.regs[0][1] and s_src_low_1) |=> clk_oe_n[1])
        else $error("Disabled serial pair 0 not floating");

    a_xtal_park_low: assert property ((!s_r.regs[1][4] && !src_clk[9]) |=> (!clk_out[9] && !clk_oe_n[9]))
        else $error("Disabled crystal output not parked low and driven");

    // One cycle after the halt is latched, even a high source phase must stay parked low
    a_stop_halts: assert property ((s_stop_req_1 and s_src_low_1) ##1 s_stop_req_1 |=> !clk_out[1])
        else $error("Stoppable serial pair kept running under stop");

    a_stop_float: assert property ((s_stop_req_1 and s_src_low_1) ##0 s_r.regs[5][7] |=> clk_oe_n[1])
        else $error("Stopped serial pair not floating in float mode");

    a_pd_float: assert property ((power_down && s_r.regs[5][3] && !src_clk[2]) |=> clk_oe_n[2])
        else $error("Powered-down serial pair not floating");

    a_video_pd_mode: assert property ((power_down && s_r.regs[1][6] && !src_clk[5])
                                      |=> clk_oe_n[5] == $past(s_r.regs[4][6]))
        else $error("Video pair power-down drive mode wrong");

    a_no_short_high: assert property ((src_clk[11] && clk_out[11] && $past(src_clk[11])) |=> clk_out[11])
        else $error("Bus clock high phase cut short");

    a_foreign_silent: assert property ((s_r.st == S_ADDR && scl_fall && s_r.bit_cnt == 4'h8
                                        && s_r.shreg[7:1] != `COCR_TARGET_ADDR) |=> sda_oe_n [*2])
        else $error("Acknowledged a foreign target address");
endmodule : cocr_ctrl

// ==== tb/cocr_host.sv ====
// Purpose: Host controller model on the two-wire serial bus
// Assumes: Open-drain wire is the AND of all drive enables, pulled up
// Notes:   The high phase of scl lasts four ref_clk cycles, the low phase eight; all changes at falling edge
`timescale 1ns/1ps
module cocr_host (
    input  wire logic ref_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_oe_n
);
    // Reserved bits that must read one, and those that must read zero
    localparam logic [5:0][7:0] ONES  = {8'h00, 8'h07, 8'h00, 8'h30, 8'h00, 8'h61};
    localparam logic [5:0][7:0] ZEROS = {8'h70, 8'h88, 8'h61, 8'h00, 8'h00, 8'h00};
    logic r;
    initial begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end
    // ==========================================================
    // Bit level
    task automatic half();
        repeat (4) @(negedge ref_clk);
    endtask : half
    // Start and repeated start share one shape: data falls while scl high
    task automatic start();
        sda_oe_n = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_oe_n = 1'b0;
        half();
        scl = 1'b0;
        half();
    endtask : start
    task automatic stop();
        sda_oe_n = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_oe_n = 1'b1;
        half();
    endtask : stop
    // Sample late in the high phase so a device answer has settled
    task automatic xbit(input logic b);
        sda_oe_n = b;
        half();
        scl = 1'b1;
        half();
        r = sda_wire;
        scl = 1'b0;
        half();
    endtask : xbit
    task automatic send(input logic [7:0] d, output logic ok);
        for (int i = 7; i >= 0; i--) xbit(d[i]);
        xbit(1'b1);
        ok = ~r;
    endtask : send
    task automatic recv(output logic [7:0] d, input logic last);
        for (int i = 0; i < 8; i++) begin
            xbit(1'b1);
            d = {d[6:0], r};
        end
        xbit(last);
    endtask : recv
    // Reserved positions are forced, so the bench can never corrupt them
    function automatic logic [7:0] legal(input logic [6:0] off, input logic [7:0] d);
        return (off < 7'h06) ? ((d | ONES[off[2:0]]) & ~ZEROS[off[2:0]]) : d;
    endfunction : legal
    // ==========================================================
    // Transfers
    task automatic wr(input logic [7:0] adr, input logic [6:0] off, input logic [7:0] d, output logic ok);
        logic a, b, c;
        start();
        send(adr, a);
        send({1'b1, off}, b);
        send(legal(off, d), c);
        stop();
        ok = a & b & c;
    endtask : wr
    task automatic rd(input logic [6:0] off, output logic [7:0] d);
        logic a;
        start();
        send(8'hd2, a);
        send({1'b1, off}, a);
        start();
        send(8'hd3, a);
        recv(d, 1'b1);
        stop();
    endtask : rd
    task automatic bwr(input logic [5:0][7:0] v);
        logic a;
        start();
        send(8'hd2, a);
        send(8'h00, a);
        send(8'h06, a);
        for (int i = 0; i < 6; i++) send(legal(7'(i), v[i]), a);
        stop();
    endtask : bwr
    task automatic brd(output logic [7:0] cnt, output logic [5:0][7:0] v);
        logic a;
        start();
        send(8'hd2, a);
        send(8'h00, a);
        start();
        send(8'hd3, a);
        recv(cnt, 1'b0);
        for (int i = 0; i < 6; i++) recv(v[i], i == 5);
        stop();
    endtask : brd
endmodule : cocr_host

// ==== tb/clock_output_control_regs_bench.sv ====
// Purpose: Self-checking bench of the clock output control bank
// Assumes: Host model drives the serial bus; bus clock and free-run sources run at half the rate of the others
// Notes:   Output checks watch eight cycles after a short settle
`timescale 1ns/1ps
`include "cocr_regs.svh"
module clock_output_control_regs_bench;
    import cocr_pkg::*;
    logic ref_clk, rst, scl, sda_wire, host_oe_n, dut_oe_n, sw_bus_clock_stop, power_down, spread_on, spread_down;
    logic [`COCR_NUM_OUTS-1:0] src_clk, clk_out, clk_oe_n;
    logic [5:0][7:0] m;
    int n_errors, cmp_count, cycles;
    assign sda_wire = host_oe_n & dut_oe_n;
    cocr_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda_wire), .sda_out(), .sda_oe_n(dut_oe_n),
        .sw_bus_clock_stop(sw_bus_clock_stop), .power_down(power_down), .src_clk(src_clk), .clk_out(clk_out),
        .clk_oe_n(clk_oe_n), .spread_on(spread_on), .spread_down(spread_down));
    cocr_host u_host (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_oe_n(host_oe_n));
    // ==========================================================
    // Clock, sources and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Bus clock sources hold each phase two cycles so a long high phase can be watched
    always @(negedge ref_clk) begin
        src_clk[10:0] <= ~src_clk[10:0];
        if (src_clk[10]) begin
            src_clk[16:11] <= ~src_clk[16:11];
        end
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors++;
            finish_test();
        end
    end
    // ==========================================================
    // Checking helpers
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    // Expected run and float per output from the model bytes and the stop inputs
    task automatic check_outs();
        logic [16:0] en, stp, pdz, run, hiz, seen;
        en = {m[2][1], m[2][0], m[2][7], m[2][6], m[2][3], m[2][2], m[1][3], m[1][4], m[1][5], m[1][2], m[1][1],
              m[1][6], m[0][4:1], m[0][7]};
        stp = {m[4][5], m[4][4], 4'hf, 6'h00, m[3][4:1], m[3][7]};
        pdz = {9'h000, m[5][1], m[5][0], m[4][6], {4{m[5][3]}}, m[5][2]};
        run = en & ~(sw_bus_clock_stop ? stp : 17'h0) & ~{17{power_down}};
        hiz = (~en & 17'h000ff) | (sw_bus_clock_stop ? stp & 17'h000ff & {17{m[5][7]}} : 17'h0) |
              (power_down ? pdz : 17'h0);
        seen = '0;
        repeat (6) @(negedge ref_clk);
        for (int k = 0; k < 8; k++) begin
            @(negedge ref_clk);
            seen |= clk_out;
        end
        chk(clk_oe_n, hiz);
        chk(seen & ~hiz, run & ~hiz);
    endtask : check_outs
    task automatic put(input logic [6:0] off, input logic [7:0] d);
        logic ok;
        u_host.wr(8'hd2, off, d, ok);
        chk(ok, 1'b1);
        m[off] = d;
    endtask : put
    task automatic readall();
        logic [7:0] cnt;
        logic [5:0][7:0] v;
        u_host.brd(cnt, v);
        chk(cnt, 8'h06);
        chk(v, m);
    endtask : readall
    // ==========================================================
    // Scenarios
    task automatic t_defaults();
        chk(spread_on, 1'b0);
        chk(spread_down, 1'b1);
        check_outs();
        readall();
    endtask : t_defaults
    // Byte access on every offset, an unmapped offset and a foreign address
    task automatic t_bytes();
        logic [5:0][7:0] v;
        logic [7:0] d;
        logic ok;
        v = {8'h8a, 8'h77, 8'h9a, 8'h35, 8'h3b, 8'h6b};
        for (int i = 0; i < 6; i++) put(7'(i), v[i]);
        readall();
        u_host.rd(7'h02, d);
        chk(d, 8'h35);
        u_host.wr(8'hd2, 7'h06, 8'h55, ok);
        u_host.rd(7'h06, d);
        chk(d, 8'h00);
        u_host.wr(8'hd4, 7'h00, 8'hff, ok);
        chk(ok, 1'b0);
        readall();
        chk({spread_on, spread_down}, 2'b10);
        check_outs();
    endtask : t_bytes
    task automatic t_block();
        m = {8'h00, 8'h07, 8'h00, 8'hfa, 8'hc4, 8'hf5};
        u_host.bwr(m);
        readall();
        chk({spread_on, spread_down}, 2'b01);
        check_outs();
    endtask : t_block
    // Software stop with float, then driven-low, then release
    task automatic t_stop();
        m = {8'h80, 8'h17, 8'h9a, 8'hff, 8'hff, 8'hff};
        u_host.bwr(m);
        sw_bus_clock_stop = 1'b1;
        check_outs();
        put(7'h05, 8'h00);
        check_outs();
        sw_bus_clock_stop = 1'b0;
        check_outs();
    endtask : t_stop
    task automatic t_pd();
        put(7'h05, 8'h0d);
        put(7'h04, 8'h47);
        power_down = 1'b1;
        check_outs();
        put(7'h05, 8'h02);
        put(7'h04, 8'h07);
        check_outs();
        power_down = 1'b0;
        check_outs();
    endtask : t_pd
    initial begin
        rst = 1'b1;
        src_clk = '0;
        sw_bus_clock_stop = 1'b0;
        power_down = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        cycles = 0;
        m = {8'h00, 8'h07, 8'h00, 8'hff, 8'hfe, 8'hff};
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        t_defaults();
        t_bytes();
        t_block();
        t_stop();
        t_pd();
        finish_test();
    end
endmodule : clock_output_control_regs_bench
